//--- include/pcl_pkg.sv
// Shared constants, types and pin bundles of the parallel config loader.
package pcl_pkg;

    // ****************************************************************
    // Clock rates and derived cycle counts
    // ****************************************************************
    localparam int CLK_MHZ = 250; // Block clock rate.
    localparam int OSC_MHZ = 10; // Internal start-up oscillator rate.
    localparam int OSC_DIV = CLK_MHZ / OSC_MHZ; // Clocks per oscillator tick.
    localparam int REQ_TO_LOW_NS = 800; // Request low to pins low, longest.
    localparam int REQ_TO_LOW_CYC = REQ_TO_LOW_NS * CLK_MHZ / 1000;
    localparam int STATUS_MIN_US = 10; // Status low pulse, least.
    localparam int STATUS_MAX_US = 40; // Status low pulse, longest.
    localparam int STATUS_US = 20; // Status low pulse that we produce.
    localparam int STATUS_CYC = STATUS_US * CLK_MHZ;
    localparam int STATUS_MIN_CYC = STATUS_MIN_US * CLK_MHZ;
    localparam int STATUS_MAX_CYC = STATUS_MAX_US * CLK_MHZ;
    localparam int POR_US = 100; // Power-on hold of the status pin.
    localparam int POR_CYC = POR_US * CLK_MHZ;
    localparam int BUSY_MIN_NS = 7; // Busy low time, least.
    localparam int BUSY_MAX_NS = 45; // Busy low time, longest.
    localparam int BUSY_MIN_CYC = (BUSY_MIN_NS * CLK_MHZ + 999) / 1000;
    localparam int BUSY_MAX_CYC = BUSY_MAX_NS * CLK_MHZ / 1000;
    localparam logic [3:0] BUSY_CYC = 4'h4; // Busy time, inside the window.
    localparam int INIT_TICKS = 136; // Start-up clock periods to user mode.
    localparam int INIT_MIN_US = 6; // Start-up time on the oscillator, least.
    localparam int INIT_MAX_US = 20; // Start-up time on the oscillator, most.
    localparam int CFG_BYTES = 1024; // Bytes in one configuration image.

    // ****************************************************************
    // Widths
    // ****************************************************************
    localparam int CNT_W = 16; // Long delay counter.
    localparam int BCNT_W = 20; // Byte counter.
    localparam int TICK_W = 8; // Start-up tick counter.
    localparam int DIV_W = 5; // Oscillator divider.

    // ****************************************************************
    // Types
    // ****************************************************************
    // Configuration sequence.
    typedef enum logic [2:0] {
        st_por, st_reset, st_status, st_load, st_error, st_init, st_user
    } pcl_state_e;

    // Every pin that arrives from outside the clock domain, except the load-complete input.
    typedef struct packed {
        logic req_n; // Reconfiguration request, low active.
        logic sel_n; // Low-active select.
        logic sel_hi; // High-active select.
        logic ws_n; // Write strobe, low active.
        logic cfg_clk; // Clocked-mode configuration clock.
        logic usr_clk; // Optional start-up clock.
        logic status_in; // Level seen on the error-status wire.
        logic mode_clk; // Strap: clocked mode when high.
        logic use_usr; // Strap: start up on the user clock when high.
        logic [7:0] data; // Configuration data.
    } pcl_pins_s;

endpackage

//--- hw/pcl_sync.sv
// Two-flop synchroniser for a bundle of asynchronous pins.
`timescale 1ns/1ns
module pcl_sync #(
    parameter int W = 1
) (
    // Clock and reset.
    input wire logic clock,
    input wire logic resetn,
    input wire logic clock_en,
    // Data.
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    logic [W-1:0] meta; // First stage, read only by the second.

    // Each bit is resolved separately; a multi-bit word may be torn for
    // one cycle, so callers qualify data with a synchronised strobe.
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            meta <= '0;
            q <= '0;
        end else if (clock_en) begin
            meta <= d;
            q <= meta;
        end
    end

endmodule

//--- hw/pcl_loader.sv
// Byte-wide configuration port with strobed and clocked loading.
`timescale 1ns/1ns
module pcl_loader #(
    parameter int POR_CYC = pcl_pkg::POR_CYC,
    parameter int STATUS_CYC = pcl_pkg::STATUS_CYC,
    parameter int CFG_BYTES = pcl_pkg::CFG_BYTES
) (
    // Clock, reset and enable.
    input wire logic clock,
    input wire logic resetn,
    input wire logic clock_en,
    // Host control pins.
    input wire logic reconfig_request_n,
    input wire logic select_low_active,
    input wire logic select_high_active,
    input wire logic write_strobe_n,
    input wire logic config_clock,
    input wire logic user_start_clock,
    input wire logic [7:0] config_data,
    // Straps.
    input wire logic clocked_parallel_mode,
    input wire logic use_user_start_clock,
    // Open-drain error-status pin.
    input wire logic error_status_n_in,
    output logic error_status_n_out,
    output logic error_status_n_oe_n,
    // Open-drain load-complete pin.
    input wire logic load_complete_in,
    output logic load_complete_out,
    output logic load_complete_oe_n,
    // Handshake and core side.
    output logic ready_not_busy,
    output logic [7:0] config_byte,
    output logic byte_valid,
    output logic osc_enable,
    output logic user_mode
);

    // ****************************************************************
    // Pin synchronisation and edge detection
    // ****************************************************************
    pcl_pkg::pcl_pins_s raw; // Pins as they arrive.
    pcl_pkg::pcl_pins_s p; // Pins after two flops.
    logic prev_ws_n; // Strobe one cycle ago.
    logic prev_cclk; // Configuration clock one cycle ago.
    logic prev_uclk; // User clock one cycle ago.

    assign raw = '{req_n: reconfig_request_n, sel_n: select_low_active,
                   sel_hi: select_high_active, ws_n: write_strobe_n,
                   cfg_clk: config_clock, usr_clk: user_start_clock,
                   status_in: error_status_n_in,
                   mode_clk: clocked_parallel_mode,
                   use_usr: use_user_start_clock, data: config_data};

    pcl_sync #(.W($bits(pcl_pkg::pcl_pins_s))) u_sync (
        .clock(clock),
        .resetn(resetn),
        .clock_en(clock_en),
        .d(raw),
        .q(p)
    );

    // Previous levels feed the edge detectors.
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            prev_ws_n <= 1'b0;
            prev_cclk <= 1'b0;
            prev_uclk <= 1'b0;
        end else if (clock_en) begin
            prev_ws_n <= p.ws_n;
            prev_cclk <= p.cfg_clk;
            prev_uclk <= p.usr_clk;
        end
    end

    pcl_pkg::pcl_state_e state; // Configuration sequence state.
    logic [pcl_pkg::CNT_W-1:0] cnt; // Delay counter of the sequence.
    logic [pcl_pkg::BCNT_W-1:0] byte_cnt; // Bytes accepted so far.
    logic [pcl_pkg::TICK_W-1:0] tick_cnt; // Start-up ticks so far.
    logic [pcl_pkg::DIV_W-1:0] osc_div; // Oscillator divider.
    logic [3:0] busy_cnt; // Remaining busy cycles.
    logic [1:0] settle; // Cycles since status was released.
    logic mode_clk; // Latched mode strap.
    logic use_usr; // Latched start-up clock strap.
    logic [7:0] data_hold; // Data seen while the strobe is low.
    logic sel_ok; // Both selects active.
    logic strobe_rise; // Selected strobe rising edge.
    logic clk_rise; // Configuration clock rising edge.
    logic overrun; // Strobe while still busy.
    logic ext_err; // Someone else pulls status low.
    logic take; // Accept a byte this cycle.
    logic tick; // One start-up clock period.

    assign sel_ok = !p.sel_n && p.sel_hi;
    assign strobe_rise = sel_ok && p.ws_n && !prev_ws_n;
    assign clk_rise = p.cfg_clk && !prev_cclk;
    assign overrun = state == pcl_pkg::st_load && !mode_clk && strobe_rise
                     && busy_cnt != 4'h0;
    // The synchronised level lags our own release, so wait it out.
    assign ext_err = state == pcl_pkg::st_load && !p.status_in
                     && settle == 2'h3;
    assign take = state == pcl_pkg::st_load && !overrun && !ext_err
                  && (mode_clk ? clk_rise : strobe_rise);
    assign tick = use_usr ? (p.usr_clk && !prev_uclk)
                          : (osc_enable && osc_div ==
                             pcl_pkg::DIV_W'(pcl_pkg::OSC_DIV - 1));

    // ****************************************************************
    // Configuration sequence
    // ****************************************************************
    // A low request restarts from any state except the power-up hold.
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            state <= pcl_pkg::st_por;
            cnt <= '0;
        end else if (clock_en) begin
            if (state != pcl_pkg::st_por && !p.req_n) begin
                state <= pcl_pkg::st_reset;
                cnt <= '0;
            end else begin
                case (state)
                    pcl_pkg::st_por: begin
                        // Status stays low for the power-on delay.
                        if (cnt == pcl_pkg::CNT_W'(POR_CYC - 1)) begin
                            if (p.req_n) begin
                                state <= pcl_pkg::st_load;
                            end
                        end else begin
                            cnt <= cnt + 1'b1;
                        end
                    end
                    pcl_pkg::st_reset: begin
                        // Request has risen again here.
                        state <= pcl_pkg::st_status;
                    end
                    pcl_pkg::st_status: begin
                        if (cnt == pcl_pkg::CNT_W'(STATUS_CYC - 1)) begin
                            state <= pcl_pkg::st_load;
                            cnt <= '0;
                        end else begin
                            cnt <= cnt + 1'b1;
                        end
                    end
                    pcl_pkg::st_load: begin
                        if (overrun || ext_err) begin
                            state <= pcl_pkg::st_error;
                        end else if (byte_cnt ==
                                     pcl_pkg::BCNT_W'(CFG_BYTES)) begin
                            state <= pcl_pkg::st_init;
                        end
                    end
                    pcl_pkg::st_init: begin
                        if (tick_cnt ==
                            pcl_pkg::TICK_W'(pcl_pkg::INIT_TICKS)) begin
                            state <= pcl_pkg::st_user;
                        end
                    end
                    default: begin
                        // Error and user mode wait for a new request.
                        state <= state;
                    end
                endcase
            end
        end
    end

    // Straps are caught while the device is held in reset states.
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            mode_clk <= 1'b0;
            use_usr <= 1'b0;
        end else if (clock_en && (state == pcl_pkg::st_por
                                  || state == pcl_pkg::st_reset)) begin
            mode_clk <= p.mode_clk;
            use_usr <= p.use_usr;
        end
    end

    // ****************************************************************
    // Byte capture and busy handshake
    // ****************************************************************
    // Data is held while the strobe is low, so a zero hold time after
    // the rising strobe does not corrupt the captured byte.
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            data_hold <= 8'h00;
            config_byte <= 8'h00;
            byte_valid <= 1'b0;
            byte_cnt <= '0;
        end else if (clock_en) begin
            if (sel_ok && !p.ws_n) begin
                data_hold <= p.data;
            end
            byte_valid <= take;
            if (take) begin
                config_byte <= mode_clk ? p.data : data_hold;
                byte_cnt <= byte_cnt + 1'b1;
            end else if (state == pcl_pkg::st_reset) begin
                byte_cnt <= '0;
            end
        end
    end

    // Busy lasts a fixed count; a strobe during it is an overrun.
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            ready_not_busy <= 1'b1;
            busy_cnt <= 4'h0;
        end else if (clock_en) begin
            if (take && !mode_clk) begin
                ready_not_busy <= 1'b0;
                busy_cnt <= pcl_pkg::BUSY_CYC;
            end else if (busy_cnt == 4'h1) begin
                ready_not_busy <= 1'b1;
                busy_cnt <= 4'h0;
            end else if (busy_cnt != 4'h0) begin
                busy_cnt <= busy_cnt - 1'b1;
            end
        end
    end

    // ****************************************************************
    // Start-up clocking
    // ****************************************************************
    // The oscillator only runs during initialization to save power.
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            osc_enable <= 1'b0;
            osc_div <= '0;
            tick_cnt <= '0;
        end else if (clock_en) begin
            osc_enable <= state == pcl_pkg::st_init && !use_usr;
            if (!osc_enable ||
                osc_div == pcl_pkg::DIV_W'(pcl_pkg::OSC_DIV - 1)) begin
                osc_div <= '0;
            end else begin
                osc_div <= osc_div + 1'b1;
            end
            if (state != pcl_pkg::st_init) begin
                tick_cnt <= '0;
            end else if (tick) begin
                tick_cnt <= tick_cnt + 1'b1;
            end
        end
    end

    // ****************************************************************
    // Pin drivers
    // ****************************************************************
    // Open-drain pins only ever drive low; release lets the pull-up win.
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            error_status_n_out <= 1'b0;
            load_complete_out <= 1'b0;
            error_status_n_oe_n <= 1'b0;
            load_complete_oe_n <= 1'b0;
            user_mode <= 1'b0;
            settle <= 2'h0;
        end else if (clock_en) begin
            error_status_n_oe_n <= !(state == pcl_pkg::st_por
                                     || state == pcl_pkg::st_reset
                                     || state == pcl_pkg::st_status
                                     || state == pcl_pkg::st_error);
            load_complete_oe_n <= state == pcl_pkg::st_init
                                  || state == pcl_pkg::st_user;
            user_mode <= state == pcl_pkg::st_user;
            if (!error_status_n_oe_n) begin
                settle <= 2'h0;
            end else if (settle != 2'h3) begin
                settle <= settle + 1'b1;
            end
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    localparam int A_REQ = pcl_pkg::REQ_TO_LOW_CYC;
    localparam int A_SMIN = pcl_pkg::STATUS_MIN_CYC;
    localparam int A_SMAX = pcl_pkg::STATUS_MAX_CYC;
    logic [pcl_pkg::CNT_W-1:0] st_len; // Cycles spent in the status pulse.

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            st_len <= '0;
        end else if (clock_en) begin
            st_len <= state == pcl_pkg::st_status ? st_len + 1'b1 : '0;
        end
    end

    default clocking @(posedge clock); endclocking
    default disable iff (!resetn || !clock_en);

    sequence s_init_exit;
        state == pcl_pkg::st_init ##1 state == pcl_pkg::st_user;
    endsequence
    sequence s_status_exit;
        state == pcl_pkg::st_status ##1 state == pcl_pkg::st_load;
    endsequence

    chk_strobe_busy: assert property (
        $rose(byte_valid) && !mode_clk |-> !ready_not_busy)
        else $error("busy not shown after byte capture");
    chk_ready_return: assert property (
        $fell(ready_not_busy) |-> !ready_not_busy[*4] ##1 ready_not_busy)
        else $error("ready did not return after busy time");
    chk_error_hold: assert property (
        state == pcl_pkg::st_error |=> !error_status_n_oe_n)
        else $error("status not held low on error");
    chk_done_release: assert property (
        $rose(load_complete_oe_n) |-> $past(byte_cnt, 2) ==
            pcl_pkg::BCNT_W'(CFG_BYTES))
        else $error("done released before all bytes");
    chk_osc_gated: assert property (
        osc_enable |-> $past(state) == pcl_pkg::st_init)
        else $error("oscillator running outside initialization");
    chk_user_pins: assert property (
        user_mode |-> error_status_n_oe_n && load_complete_oe_n)
        else $error("pins not released in user mode");
    chk_done_low: assert property (
        !(state inside {pcl_pkg::st_init, pcl_pkg::st_user})
        |=> !load_complete_oe_n)
        else $error("done released during configuration");
    chk_request_pull: assert property (
        $fell(p.req_n) |-> ##[1:A_REQ]
            (!error_status_n_oe_n && !load_complete_oe_n))
        else $error("request low did not pull pins low in time");
    chk_status_max: assert property (
        state == pcl_pkg::st_status |-> st_len < A_SMAX)
        else $error("status pulse too long");
    chk_status_min: assert property (
        s_status_exit |-> $past(st_len) >= A_SMIN)
        else $error("status pulse too short");
    chk_init_ticks: assert property (
        s_init_exit |-> $past(tick_cnt) ==
            pcl_pkg::TICK_W'(pcl_pkg::INIT_TICKS))
        else $error("start-up tick count wrong");

endmodule

//--- dv/pcl_host.sv
// Host model that drives the byte port and request pin of the loader.
`timescale 1ns/1ns
module pcl_host (
    // Clock and observed wires.
    input wire logic clock,
    input wire logic status_wire,
    input wire logic done_wire,
    // Pins that the host drives.
    output logic reconfig_request_n,
    output logic select_low_active,
    output logic select_high_active,
    output logic write_strobe_n,
    output logic config_clock,
    output logic user_start_clock,
    output logic [7:0] config_data
);
    // Idle levels: request high, deselected, link clocks parked low.
    initial begin
        reconfig_request_n = 1'b1;
        select_low_active = 1'b1;
        select_high_active = 1'b0;
        write_strobe_n = 1'b1;
        config_clock = 1'b0;
        user_start_clock = 1'b0;
        config_data = 8'hFF;
    end

    // Restarts loading; reports pin levels 800 ns after the request fell
    // and the cycles from request rise to status release.
    task automatic restart(output int rel, output logic low);
        @(negedge clock);
        select_low_active = 1'b1;
        select_high_active = 1'b0;
        reconfig_request_n = 1'b0;
        repeat (200) @(negedge clock);
        low = (status_wire === 1'b0) && (done_wire === 1'b0);
        repeat (9800) @(negedge clock);
        reconfig_request_n = 1'b1;
        rel = 0;
        while (status_wire !== 1'b1 && rel < 12000) begin
            @(negedge clock);
            rel++;
        end
        // Both the 40 us and the 1 us margin are kept before any data.
        repeat (10250 - rel) @(negedge clock);
        select_low_active = 1'b0;
        select_high_active = 1'b1;
    endtask

    // One strobed byte; a short high time makes an overrun on purpose.
    task automatic strobe_byte(input logic [7:0] b, input int lo,
                               input int hi);
        @(negedge clock);
        config_data = b;
        write_strobe_n = 1'b0;
        repeat (lo) @(negedge clock);
        write_strobe_n = 1'b1;
        repeat (hi) @(negedge clock);
        // Released data shows the inverse, never the stale byte.
        config_data = ~b;
    endtask

    // One clocked byte on an 80 ns link clock that stops between frames.
    // The first edge keeps the previous released data apart from this byte.
    task automatic clock_byte(input logic [7:0] b);
        @(negedge clock);
        config_data = b;
        repeat (9) @(negedge clock);
        config_clock = 1'b1;
        repeat (10) @(negedge clock);
        config_clock = 1'b0;
        config_data = ~b;
    endtask

    // Rising edges on the optional start-up clock.
    task automatic usr_ticks(input int n);
        repeat (n) begin
            repeat (5) @(negedge clock);
            user_start_clock = 1'b1;
            repeat (5) @(negedge clock);
            user_start_clock = 1'b0;
        end
    endtask
endmodule

//--- dv/test_parallel_config_loader.sv
// Self-checking bench for the parallel config loader.
`timescale 1ns/1ns
module test_parallel_config_loader;
    localparam int NB = 8; // Short image keeps the run brief.
    logic clock = 1'b0;
    logic resetn = 1'b0;
    logic clock_en = 1'b1;
    logic clocked_parallel_mode = 1'b0;
    logic use_user_start_clock = 1'b0;
    logic reconfig_request_n, select_low_active, select_high_active;
    logic write_strobe_n, config_clock, user_start_clock;
    logic [7:0] config_data, config_byte;
    logic error_status_n_out, error_status_n_oe_n;
    logic load_complete_out, load_complete_oe_n;
    logic ready_not_busy, byte_valid, osc_enable, user_mode;
    logic [7:0] got [$];
    int fail_count = 0;
    int num_checks = 0;
    logic ext_pull = 1'b0; // Another device pulling status low.
    // Both pins are open drain with a pull-up.
    wire status_wire = error_status_n_oe_n && !ext_pull ? 1'b1
                       : error_status_n_out;
    wire done_wire = load_complete_oe_n ? 1'b1 : load_complete_out;

    pcl_loader #(.POR_CYC(50), .CFG_BYTES(NB)) DUT (
        .clock, .resetn, .clock_en, .reconfig_request_n,
        .select_low_active, .select_high_active, .write_strobe_n,
        .config_clock, .user_start_clock, .config_data,
        .clocked_parallel_mode, .use_user_start_clock,
        .error_status_n_in(status_wire), .error_status_n_out,
        .error_status_n_oe_n, .load_complete_in(done_wire),
        .load_complete_out, .load_complete_oe_n, .ready_not_busy,
        .config_byte, .byte_valid, .osc_enable, .user_mode);
    pcl_host host (
        .clock, .status_wire, .done_wire, .reconfig_request_n,
        .select_low_active, .select_high_active, .write_strobe_n,
        .config_clock, .user_start_clock, .config_data);

    // Clock and a monitor of every accepted byte.
    initial forever #2 clock = ~clock;
    always @(posedge clock) begin
        if (byte_valid === 1'b1) begin
            got.push_back(config_byte);
        end
    end

    // ****************************************************************
    // Checking and closing
    // ****************************************************************
    task automatic check(input string what, input logic [31:0] exp,
                         input logic [31:0] seen);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic stop_test;
        if (fail_count == 0 && num_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // Restart with fresh straps and judge the request timing.
    task automatic do_restart(input logic cm, input logic usr);
        int rel;
        logic low;
        clocked_parallel_mode = cm;
        use_user_start_clock = usr;
        host.restart(rel, low);
        check("pins low after request", 1, low);
        check("status release time", 1, rel > 2500 && rel < 10000);
        got.delete();
    endtask
    task automatic check_bytes(input logic [7:0] base);
        logic [7:0] e;
        check("bytes taken", NB, got.size());
        for (int i = 0; i < NB && i < got.size(); i++) begin
            e = base + 8'(i);
            check("byte value", e, got[i]);
        end
        check("done after last byte", 1, done_wire);
    endtask

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_power_up;
        repeat (20) @(negedge clock);
        check("status in power-on hold", 0, status_wire);
        check("done in power-on hold", 0, done_wire);
        repeat (60) @(negedge clock);
        check("status after hold", 1, status_wire);
        // A neighbour pulling status low while loading must latch an error.
        ext_pull = 1'b1;
        repeat (10) @(negedge clock);
        ext_pull = 1'b0;
        repeat (10) @(negedge clock);
        check("status after external error", 0, status_wire);
    endtask
    // Strobed image, busy timing, start-up on the internal oscillator.
    task automatic t_strobed;
        int n;
        do_restart(1'b0, 1'b0);
        for (int i = 0; i < NB; i++) begin
            check("status before byte", 1, status_wire);
            check("done before byte", 0, done_wire);
            host.strobe_byte(8'h5A + 8'(i), 4, 2);
            n = 0;
            repeat (10) begin
                @(negedge clock);
                if (ready_not_busy === 1'b0) n++;
            end
            check("busy cycles", 4, n);
            check("ready again", 1, ready_not_busy);
        end
        check_bytes(8'h5A);
        check("oscillator on", 1, osc_enable);
        n = 10;
        while (user_mode !== 1'b1 && n < 6000) begin
            @(negedge clock);
            n++;
        end
        check("start-up time", 1, n >= 1500 && n <= 5000);
        check("oscillator off", 0, osc_enable);
        check("status in user mode", 1, status_wire);
        check("done in user mode", 1, done_wire);
    endtask
    // A second strobe while busy must end in a held error.
    task automatic t_overrun;
        do_restart(1'b0, 1'b0);
        host.strobe_byte(8'h11, 4, 1);
        host.strobe_byte(8'h22, 2, 12);
        check("status after overrun", 0, status_wire);
        repeat (3000) @(negedge clock);
        check("status held low", 0, status_wire);
        check("done after overrun", 0, done_wire);
    endtask
    // Clocked image after an error, start-up on the user clock.
    task automatic t_clocked;
        do_restart(1'b1, 1'b1);
        for (int i = 0; i < NB; i++) begin
            check("status before byte", 1, status_wire);
            host.clock_byte(8'hF0 + 8'(i));
            check("ready in clocked mode", 1, ready_not_busy);
        end
        check_bytes(8'hF0);
        check("oscillator idle", 0, osc_enable);
        host.usr_ticks(135);
        repeat (10) @(negedge clock);
        check("user mode at 135", 0, user_mode);
        host.usr_ticks(1);
        repeat (10) @(negedge clock);
        check("user mode at 136", 1, user_mode);
    endtask

    // Main sequence: reset for three cycles, then every scenario.
    initial begin
        repeat (3) @(negedge clock);
        resetn = 1'b1;
        t_power_up();
        t_strobed();
        t_overrun();
        t_clocked();
        stop_test();
    end
    // Watchdog well beyond the roughly 70,000 cycles the tests need.
    initial begin
        #400000;
        fail_count++;
        stop_test();
    end
endmodule
